// [bench/dcc_analog_model.sv]
// Analog side model: comparator levels and port pin levels
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model
    import dcc_pkg::*;
(
    input  wire logic                      firstAbove,
    input  wire logic                      secondAbove,
    input  wire logic [dcc_pkg::PIN_W-1:0] padLevel,
    input  wire logic [dcc_pkg::PIN_W-1:0] pinOut,
    input  wire logic [dcc_pkg::PIN_W-1:0] pinDriveN,
    output var  logic                      firstRaw,
    output var  logic                      secondRaw,
    output var  logic [dcc_pkg::PIN_W-1:0] pinIn
);
    // Driven pins show the block's data, released pins the outside level
    always_comb begin
        firstRaw = firstAbove;
        secondRaw = secondAbove;
        for (int i = 0; i < PIN_W; i++) begin
            pinIn[i] = pinDriveN[i] ? padLevel[i] : pinOut[i];
        end
    end
endmodule : dcc_analog_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench of the dual comparator control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dcc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        firstRaw;
    logic        secondRaw;
    logic [5:0]  pinIn;
    logic [5:0]  pinOut;
    logic [5:0]  pinDriveN;
    logic        refToPlus;
    logic        minusSwitch;
    logic        comparatorsOff;
    logic [2:0]  comparatorMode;
    logic        irqRequest;
    logic        wakeRequest;
    logic        firstAbove = 1'b0;
    logic        secondAbove = 1'b0;
    logic [5:0]  padLevel = 6'h00;
    logic [31:0] rv;
    logic        re;
    int          fails = 0;
    int          numChecks = 0;
    int          cycles = 0;
    localparam logic [11:0] A_CTRL = {IDX_CMP_CTRL, 2'b00};
    localparam logic [11:0] A_FLAG = {IDX_FLAGS_TWO, 2'b00};
    localparam logic [11:0] A_EN = {IDX_ENABLES, 2'b00};
    localparam logic [11:0] A_GIE = {IDX_GLOBAL_IRQ, 2'b00};
    localparam logic [11:0] A_DIR = {IDX_PORT_DIR, 2'b00};
    localparam logic [11:0] A_PORT = {IDX_PORT_PINS, 2'b00};

    initial begin
        forever #50 clk = ~clk;
    end

    dcc_top dcc_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .firstRaw(firstRaw), .secondRaw(secondRaw),
        .pinIn(pinIn), .pinOut(pinOut), .pinDriveN(pinDriveN), .refToPlus(refToPlus),
        .minusSwitch(minusSwitch), .comparatorsOff(comparatorsOff),
        .comparatorMode(comparatorMode), .irqRequest(irqRequest),
        .wakeRequest(wakeRequest));

    dcc_analog_model dcc_analog_model_inst (.firstAbove(firstAbove),
        .secondAbove(secondAbove), .padLevel(padLevel), .pinOut(pinOut),
        .pinDriveN(pinDriveN), .firstRaw(firstRaw), .secondRaw(secondRaw),
        .pinIn(pinIn));

    // ****************************************
    // Bus cycles and comparison
    // ****************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        numChecks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        repeat (8) @(posedge clk);
        chk({comparatorsOff, comparatorMode}, 4'hf, "reset mode");
        apb(1'b0, A_CTRL, 32'h0);
        chk(rv, 32'h07, "reset control");
        apb(1'b0, A_DIR, 32'h0);
        chk(rv, 32'h3f, "reset direction");
        apb(1'b0, A_FLAG, 32'h0);
        chk(rv, 32'h00, "reset flags");
    endtask : t_reset

    // Each of the eight modes reaches the mode, reference and off outputs
    task automatic t_modes;
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, A_CTRL, m);
            repeat (2) @(posedge clk);
            chk(comparatorMode, m, "mode out");
            chk(refToPlus, m == 6, "reference select");
            chk(comparatorsOff, m == 7, "comparators off");
        end
    endtask : t_modes

    task automatic t_fields;
        apb(1'b1, A_CTRL, 32'hce);
        repeat (8) @(posedge clk);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rv, 32'h0e, "result bits ignore writes");
        chk(minusSwitch, 1'b1, "switch high");
        apb(1'b1, A_CTRL, 32'h36);
        repeat (8) @(posedge clk);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rv, 32'hf6, "inverted results");
        chk(minusSwitch, 1'b0, "switch low");
        firstAbove <= 1'b1;
        repeat (8) @(posedge clk);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rv, 32'hb6, "first result");
        secondAbove <= 1'b1;
        repeat (8) @(posedge clk);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rv, 32'h36, "second result");
    endtask : t_fields

    task automatic t_flag;
        apb(1'b1, A_FLAG, 32'h0);
        apb(1'b0, A_FLAG, 32'h0);
        chk(rv, 32'h00, "flag cleared");
        apb(1'b1, A_EN, 32'h40);
        apb(1'b1, A_GIE, 32'hc0);
        firstAbove <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b0, A_FLAG, 32'h0);
        chk(rv, 32'h40, "change sets flag");
        chk({irqRequest, wakeRequest}, 2'b11, "request and wake");
        apb(1'b1, A_FLAG, 32'h0);
        apb(1'b0, A_FLAG, 32'h0);
        chk(rv, 32'h40, "mismatch keeps flag");
        apb(1'b0, A_CTRL, 32'h0);
        apb(1'b1, A_FLAG, 32'h0);
        apb(1'b0, A_FLAG, 32'h0);
        chk(rv, 32'h00, "flag clears after access");
        chk(irqRequest, 1'b0, "no request");
        apb(1'b1, A_FLAG, 32'h40);
        apb(1'b1, A_GIE, 32'h00);
        repeat (2) @(posedge clk);
        chk({irqRequest, wakeRequest}, 2'b01, "global off");
        apb(1'b0, A_FLAG, 32'h0);
        chk(rv, 32'h40, "software set flag");
        apb(1'b1, A_EN, 32'h00);
        apb(1'b1, A_FLAG, 32'h0);
    endtask : t_flag

    task automatic t_pins;
        apb(1'b1, A_CTRL, 32'h03);
        apb(1'b1, A_DIR, 32'h00);
        repeat (2) @(posedge clk);
        chk(pinDriveN, 6'h00, "drivers on");
        chk(pinOut[5:4], {secondAbove, firstAbove}, "pins follow");
        firstAbove <= 1'b1;
        repeat (2) @(posedge clk);
        chk(pinOut[5:4], 2'b11, "pins follow change");
        apb(1'b1, A_DIR, 32'h3f);
        padLevel <= 6'h3f;
        repeat (8) @(posedge clk);
        chk(pinDriveN, 6'h3f, "drivers off");
        apb(1'b0, A_PORT, 32'h0);
        chk(rv & 32'hf, 32'h0, "analog lines read 0");
        apb(1'b1, A_CTRL, 32'h07);
        apb(1'b0, A_PORT, 32'h0);
        chk(rv & 32'hf, 32'hf, "digital lines");
    endtask : t_pins

    task automatic t_err;
        apb(1'b0, 12'h004, 32'h0);
        chk(re, 1'b1, "unmapped error");
        chk(rv, 32'h0, "unmapped read");
        apb(1'b1, A_CTRL + 12'h001, 32'h05);
        chk(re, 1'b1, "unaligned write");
        apb(1'b0, A_CTRL, 32'h0);
        chk(rv[5:0], 6'h07, "control unchanged");
    endtask : t_err

    // Mid-run reset from a non-default setting
    task automatic t_rereset;
        apb(1'b1, A_CTRL, 32'h36);
        apb(1'b1, A_DIR, 32'h00);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({pinDriveN, comparatorsOff, comparatorMode}, {6'h3f, 4'hf}, "reset outputs");
        repeat (8) @(posedge clk);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rv, 32'hc7, "control after reset");
    endtask : t_rereset

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_fields();
        t_flag();
        t_pins();
        t_err();
        t_rereset();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire

// [verilog/dcc_pkg.sv]
// Register map, field positions and reset values of the dual comparator control
package dcc_pkg;
    localparam int         DATA_W         = 32;
    localparam int         ADDR_W         = 12;
    localparam int         REG_W          = 8;
    localparam int         PIN_W          = 6;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_PORT_PINS  = 10'h005;
    localparam logic [9:0] IDX_GLOBAL_IRQ = 10'h00b;
    localparam logic [9:0] IDX_FLAGS_TWO  = 10'h00d;
    localparam logic [9:0] IDX_PORT_DIR   = 10'h085;
    localparam logic [9:0] IDX_ENABLES    = 10'h08d;
    localparam logic [9:0] IDX_CMP_CTRL   = 10'h09c;
    // Comparator control, interrupt enable, change flag and port pin field positions
    localparam int         SECOND_RESULT  = 7;
    localparam int         FIRST_RESULT   = 6;
    localparam int         SECOND_INVERT  = 5;
    localparam int         FIRST_INVERT   = 4;
    localparam int         INPUT_SWITCH   = 3;
    localparam int         MODE_MSB       = 2;
    localparam int         GLOBAL_EN_BIT  = 7;
    localparam int         PERIPH_EN_BIT  = 6;
    localparam int         CHANGE_BIT     = 6;
    localparam int         OUT_PIN_ONE    = 4;
    localparam int         OUT_PIN_TWO    = 5;
    // Reset values
    localparam logic [7:0] RST_CMP_CTRL   = 8'h07;
    localparam logic [5:0] RST_PORT_DIR   = 6'h3f;
    localparam logic [7:0] RST_GLOBAL_IRQ = 8'h00;
    localparam logic [7:0] RST_ENABLES    = 8'h00;
    localparam logic [5:0] RST_PORT_DATA  = 6'h00;
    // Modes
    localparam logic [2:0] MODE_REF       = 3'h6;
    localparam logic [2:0] MODE_OFF       = 3'h7;
    localparam logic [7:0] OUT_MODE_MASK  = 8'h28;
endpackage : dcc_pkg

// [verilog/dcc_sync.sv]
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dcc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async,
    output var  logic [W-1:0] sync
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_sync;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_sync[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync   <= '0;
        end else begin
            stage1 <= async;
            stage2 <= stage1;
            stage3 <= stage2;
            sync   <= next_sync;
        end
    end
endmodule : dcc_sync
`default_nettype wire

// [verilog/dcc_top.sv]
// APB control and status logic of a dual analog comparator unit
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Bit 7 reads second comparator result, plus above minus gives 1, inverted on request.
// - Bit 6 reads first comparator result under its own inversion bit.
// - Bits 5 and 4 invert second and first results when set.
// - In mode 110 input switch selects minus inputs: 1 lines 3/2, 0 lines 0/1.
// - Low three bits hold the mode; direction register governs pin drivers.
// - Mode 110 feeds internal reference to both plus inputs.
// - Result bits are read-only; other control fields are writable.
// - Output modes route comparator results to port lines four and five.
// - Direction bits still enable or disable drivers of lines four and five.
// - Any change of either result sets the change flag.
// - Flag clears only by writing 0; writing 1 sets it.
// - Request only with all three enables set; flag sets regardless.
// - Mismatch keeps setting flag until a control register access ends it.
// - A change during a control read still sets the flag; it is never missed.
// - Comparators and their interrupt keep working in Sleep and can wake.
// - Sleep and wake leave the control register unchanged.
// - Every reset loads control register with 0x07, comparators off.
// - Analog-input pins read as 0 from the port register.
module dcc_top
    import dcc_pkg::*;
#(
    parameter logic [7:0] outModeMask = OUT_MODE_MASK
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [dcc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [dcc_pkg::DATA_W-1:0] pwdata,
    output var  logic [dcc_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic                       firstRaw,
    input  wire logic                       secondRaw,
    input  wire logic [dcc_pkg::PIN_W-1:0]  pinIn,
    output var  logic [dcc_pkg::PIN_W-1:0]  pinOut,
    output var  logic [dcc_pkg::PIN_W-1:0]  pinDriveN,
    output var  logic                       refToPlus,
    output var  logic                       minusSwitch,
    output var  logic                       comparatorsOff,
    output var  logic [2:0]                 comparatorMode,
    output var  logic                       irqRequest,
    output var  logic                       wakeRequest
);
    import dcc_pkg::*;

    // ********************************************************************
    // Synchronisers
    // ********************************************************************
    logic [1:0]       resultSync;
    logic [PIN_W-1:0] pinSync;

    dcc_sync #(.W(2)) u_result_sync (
        .clk   (clk),
        .rst   (rst),
        .async ({secondRaw, firstRaw}),
        .sync  (resultSync)
    );

    dcc_sync #(.W(PIN_W)) u_pin_sync (
        .clk   (clk),
        .rst   (rst),
        .async (pinIn),
        .sync  (pinSync)
    );

    // ********************************************************************
    // Register state
    // ********************************************************************
    logic [5:0]       cmpCtrl;
    logic [5:0]       portDirection;
    logic [5:0]       portData;
    logic [7:0]       globalControl;
    logic [7:0]       enablesTwo;
    logic             changeFlag;
    logic [1:0]       resultLatch;
    logic [5:0]       next_cmpCtrl;
    logic [5:0]       next_portDirection;
    logic [5:0]       next_portData;
    logic [7:0]       next_globalControl;
    logic [7:0]       next_enablesTwo;
    logic             next_changeFlag;
    logic [1:0]       next_resultLatch;

    logic             secondInvert;
    logic             firstInvert;
    logic             inputSwitch;
    logic [2:0]       comparatorModeField;
    logic [1:0]       resultNow;
    logic             mismatch;
    logic             outMode;
    logic [3:0]       analogMask;

    assign secondInvert        = cmpCtrl[SECOND_INVERT];
    assign firstInvert         = cmpCtrl[FIRST_INVERT];
    assign inputSwitch         = cmpCtrl[INPUT_SWITCH];
    assign comparatorModeField = cmpCtrl[MODE_MSB:0];
    // Polarity applied before read-back and change detection
    assign resultNow = {resultSync[1] ^ secondInvert,
                        resultSync[0] ^ firstInvert};
    assign mismatch  = (resultNow != resultLatch);
    assign outMode   = outModeMask[comparatorModeField];
    // Every mode except off claims lines zero to three as analog
    assign analogMask = (comparatorModeField == MODE_OFF) ? 4'h0 : 4'hf;

    // ********************************************************************
    // APB decode
    // ********************************************************************
    logic [9:0] regIndex;
    logic       aligned;
    logic       hitCtrl;
    logic       hitMapped;
    logic       setupPhase;
    logic       accessDone;
    logic       writeDone;

    assign regIndex   = paddr[11:2];
    assign aligned    = (paddr[1:0] == 2'h0);
    assign hitCtrl    = aligned && (regIndex == IDX_CMP_CTRL);
    assign hitMapped  = aligned && (regIndex == IDX_PORT_PINS ||
                                    regIndex == IDX_GLOBAL_IRQ ||
                                    regIndex == IDX_FLAGS_TWO ||
                                    regIndex == IDX_PORT_DIR ||
                                    regIndex == IDX_ENABLES ||
                                    regIndex == IDX_CMP_CTRL);
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign writeDone  = accessDone && pwrite && hitMapped;

    // ********************************************************************
    // Register next state
    // ********************************************************************
    always_comb begin
        next_cmpCtrl       = cmpCtrl;
        next_portDirection = portDirection;
        next_portData      = portData;
        next_globalControl = globalControl;
        next_enablesTwo    = enablesTwo;
        next_resultLatch   = resultLatch;
        next_changeFlag    = changeFlag;
        if (writeDone) begin
            case (regIndex)
                IDX_CMP_CTRL:   next_cmpCtrl       = pwdata[5:0];
                IDX_PORT_DIR:   next_portDirection = pwdata[5:0];
                IDX_PORT_PINS:  next_portData      = pwdata[5:0];
                IDX_GLOBAL_IRQ: next_globalControl = pwdata[7:0];
                IDX_ENABLES:    next_enablesTwo    = pwdata[7:0];
                IDX_FLAGS_TWO:  next_changeFlag    = pwdata[CHANGE_BIT];
                default:        next_changeFlag    = changeFlag;
            endcase
        end
        // Any access of the control register ends the mismatch
        if (accessDone && hitCtrl) begin
            next_resultLatch = resultNow;
        end
        // Hardware set wins over a software clear
        if (mismatch) begin
            next_changeFlag = 1'b1;
        end
    end

    // Sleep is not seen here: state holds across it unchanged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmpCtrl       <= RST_CMP_CTRL[5:0];
            portDirection <= RST_PORT_DIR;
            portData      <= RST_PORT_DATA;
            globalControl <= RST_GLOBAL_IRQ;
            enablesTwo    <= RST_ENABLES;
            resultLatch   <= 2'h0;
            changeFlag    <= 1'b0;
        end else begin
            cmpCtrl       <= next_cmpCtrl;
            portDirection <= next_portDirection;
            portData      <= next_portData;
            globalControl <= next_globalControl;
            enablesTwo    <= next_enablesTwo;
            resultLatch   <= next_resultLatch;
            changeFlag    <= next_changeFlag;
        end
    end

    // ********************************************************************
    // APB answer
    // ********************************************************************
    logic [DATA_W-1:0] next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic [7:0]        readByte;

    always_comb begin
        readByte = 8'h00;
        case (regIndex)
            IDX_CMP_CTRL:   readByte = {resultNow, cmpCtrl};
            IDX_PORT_DIR:   readByte = {2'h0, portDirection};
            IDX_PORT_PINS:  readByte = {2'h0, pinSync[5:4],
                                        pinSync[3:0] & ~analogMask};
            IDX_GLOBAL_IRQ: readByte = globalControl;
            IDX_ENABLES:    readByte = enablesTwo;
            IDX_FLAGS_TWO:  readByte = {1'b0, changeFlag, 6'h00};
            default:        readByte = 8'h00;
        endcase
        next_pready  = setupPhase && !pready;
        next_pslverr = setupPhase && !pready && !hitMapped;
        next_prdata  = prdata;
        if (setupPhase && !pready) begin
            next_prdata = (hitMapped && !pwrite) ? {24'h000000, readByte} : '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ********************************************************************
    // Pins, analog steering and interrupt outputs
    // ********************************************************************
    logic [PIN_W-1:0] next_pinOut;
    logic             next_irqRequest;
    logic             next_wakeRequest;

    always_comb begin
        next_pinOut = portData;
        if (outMode) begin
            // Raw comparator level, not the synchronised copy
            next_pinOut[OUT_PIN_ONE] = firstRaw ^ firstInvert;
            next_pinOut[OUT_PIN_TWO] = secondRaw ^ secondInvert;
        end
        next_irqRequest  = changeFlag && enablesTwo[CHANGE_BIT] &&
                           globalControl[PERIPH_EN_BIT] &&
                           globalControl[GLOBAL_EN_BIT];
        next_wakeRequest = changeFlag && enablesTwo[CHANGE_BIT];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut         <= '0;
            pinDriveN      <= RST_PORT_DIR;
            refToPlus      <= 1'b0;
            minusSwitch    <= 1'b0;
            comparatorsOff <= 1'b1;
            comparatorMode <= MODE_OFF;
            irqRequest     <= 1'b0;
            wakeRequest    <= 1'b0;
        end else begin
            pinOut         <= next_pinOut;
            pinDriveN      <= portDirection;
            refToPlus      <= (comparatorModeField == MODE_REF);
            minusSwitch    <= (comparatorModeField == MODE_REF) && inputSwitch;
            comparatorsOff <= (comparatorModeField == MODE_OFF);
            comparatorMode <= comparatorModeField;
            irqRequest     <= next_irqRequest;
            wakeRequest    <= next_wakeRequest;
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ctrl_read;
        setupPhase && !pready && hitCtrl && !pwrite;
    endsequence

    sequence s_ctrl_write;
        accessDone && pwrite && hitCtrl;
    endsequence

    a_result_read: assert property (s_ctrl_read |=>
        prdata[7:6] == {$past(resultSync[1]) ^ $past(secondInvert),
                        $past(resultSync[0]) ^ $past(firstInvert)})
        else $error("result bits read back wrong");

    a_invert_write: assert property (s_ctrl_write |=>
        secondInvert == $past(pwdata[5]) && firstInvert == $past(pwdata[4]))
        else $error("inversion bits not written");

    a_ref_select: assert property (
        comparatorModeField == MODE_REF |=> refToPlus)
        else $error("reference not steered in mode 110");

    a_minus_switch: assert property (
        (comparatorModeField != MODE_REF) |=> !minusSwitch)
        else $error("input switch acts outside mode 110");

    a_pin_result: assert property (outMode |=>
        pinOut[OUT_PIN_ONE] == ($past(firstRaw) ^ $past(firstInvert)))
        else $error("pin does not carry first result");

    a_pin_drive: assert property (
        ##1 pinDriveN[5:4] == $past(portDirection[5:4]))
        else $error("direction bits not driving pins");

    a_flag_set: assert property (mismatch |=> changeFlag)
        else $error("change flag missed a mismatch");

    a_flag_clear: assert property (
        (writeDone && regIndex == IDX_FLAGS_TWO && !pwdata[CHANGE_BIT] && !mismatch)
        |=> !changeFlag)
        else $error("flag did not clear on write of 0");

    a_irq_gate: assert property (
        !globalControl[GLOBAL_EN_BIT] ##1 !globalControl[GLOBAL_EN_BIT] |-> !irqRequest)
        else $error("request raised with global enable clear");

    a_analog_zero: assert property (
        (setupPhase && !pready && hitMapped && regIndex == IDX_PORT_PINS &&
         comparatorModeField != MODE_OFF) |=> prdata[3:0] == 4'h0)
        else $error("analog pins did not read as zero");

    a_pin_two: assert property (outMode |=>
        pinOut[OUT_PIN_TWO] == ($past(secondRaw) ^ $past(secondInvert)))
        else $error("pin does not carry second result");

    a_read_flag: assert property (
        (mismatch && accessDone && hitCtrl && !pwrite) |=> changeFlag)
        else $error("change flag lost during a control read");

    a_wake_gate: assert property (
        !enablesTwo[CHANGE_BIT] ##1 !enablesTwo[CHANGE_BIT] |-> !wakeRequest)
        else $error("wake raised with comparator enable clear");

    a_mode_out: assert property (
        ##1 comparatorMode == $past(comparatorModeField))
        else $error("mode output does not follow the mode field");
endmodule : dcc_top
`default_nettype wire
